/* verilog/cswd_host.sv */
// Purpose: Link controller driven by software over AXI4-Lite
// Assumes: One write at a time; the serial clock is CLK divided
// Notes: Command writes while busy are dropped, check busy first
`timescale 1ns/100ps
module cswd_host #(
  parameter int QCYC = cswd_pkg::QUARTER_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [cswd_pkg::AXI_AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [cswd_pkg::AXI_AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  cswd_link_if.host LINK
);
  import cswd_pkg::*;

  localparam logic [7:0] QLAST = 8'(QCYC - 1);

  cswd_hstate_e state;
  logic [1:0] phase;
  logic [4:0] bit_idx;
  logic [FRAME_BITS-1:0] tx;
  logic [7:0] q_cnt;
  logic tick;
  logic scl;
  logic sda_oe;
  logic dev_rst_n;
  logic nack;
  logic sda_in;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [31:0] rd_word;
  logic rd_ok;
  logic write_fire;
  logic launch;
  logic cmd_reserved;
  logic [15:0] cmd;
  logic [8:0] cfg;

  cswd_sync #(
    .W(1)
  ) u_sda (
    .clk(CLK),
    .d(LINK.sda),
    .q(sda_in)
  );

  assign write_fire = !AWREADY && !WREADY && !BVALID;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                  {8{wstrb[1]}}, {8{wstrb[0]}}};

  always_comb begin
    merged = (wdata & wmask);
    if (waddr == REG_CMD) begin
      merged = merged | ({16'h0000, cmd} & ~wmask);
    end else begin
      merged = merged | ({23'h000000, cfg} & ~wmask);
    end
  end

  // Reserved X codes reach no switch, so they never go on the wire
  assign cmd_reserved = (merged[X_MSB-1:X_LSB+1] == 2'b11);
  assign launch = write_fire && waddr == REG_CMD && state == H_IDLE &&
                  dev_rst_n && !cmd_reserved;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      AWREADY <= 1'b1;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      waddr <= AWADDR;
    end else if (write_fire) begin
      AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WREADY <= 1'b1;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      wdata <= WDATA;
      wstrb <= WSTRB;
    end else if (write_fire) begin
      WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      BVALID <= 1'b0;
      BRESP <= AXI_OKAY;
    end else if (write_fire) begin
      BVALID <= 1'b1;
      if (waddr == REG_CMD) begin
        BRESP <= cmd_reserved ? AXI_SLVERR : AXI_OKAY;
      end else begin
        BRESP <= (waddr == REG_CFG) ? AXI_OKAY : AXI_SLVERR;
      end
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd <= CMD_RESET;
      cfg <= CFG_RESET;
    end else if (launch) begin
      cmd <= merged[15:0];
    end else if (write_fire && waddr == REG_CFG) begin
      cfg <= merged[8:0];
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (ARADDR)
      REG_CMD: rd_word = {16'h0000, cmd};
      REG_CFG: rd_word = {23'h000000, cfg};
      REG_STATUS: begin
        rd_word[STAT_BUSY] = (state != H_IDLE);
        rd_word[STAT_NACK] = nack;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= AXI_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Device reset follows the config bit; held low during our reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dev_rst_n <= 1'b0;
    end else if (state == H_IDLE) begin
      // Reset only moves between frames, never under a transfer
      dev_rst_n <= !cfg[CFG_RST_POS];
    end
  end

  // Quarter-period timer for the serial clock
  assign tick = (q_cnt == 8'h00);
  always_ff @(posedge CLK) begin
    if (SRST || state == H_IDLE || tick) begin
      q_cnt <= QLAST;
    end else begin
      q_cnt <= q_cnt - 8'h01;
    end
  end

  // Acknowledge slots: a high data line means nobody answered
  always_ff @(posedge CLK) begin
    if (SRST || launch) begin
      nack <= 1'b0;
    end else if (tick && state == H_BITS && phase == 2'h2 &&
                 (bit_idx == ACK_ADDR || bit_idx == ACK_B1 ||
                  bit_idx == ACK_B2) && sda_in) begin
      nack <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= H_IDLE;
      phase <= 2'h0;
      bit_idx <= 5'h00;
      tx <= '0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
    end else if (launch) begin
      state <= H_START;
      phase <= 2'h0;
      bit_idx <= 5'h00;
      // Ack slots are sent as ones so the line is released
      tx <= {BUS_ADDR_HI, cfg[2:0], !RW_READ, 1'b1,
             merged[15:8], 1'b1, merged[7:0], 1'b1};
    end else if (tick && state != H_IDLE) begin
      phase <= phase + 2'h1;
      unique case (state)
        H_START: begin
          if (phase == 2'h0) sda_oe <= 1'b1;
          if (phase == 2'h2) scl <= 1'b0;
          if (phase == 2'h3) state <= H_BITS;
        end
        H_BITS: begin
          if (phase == 2'h0) sda_oe <= !tx[FRAME_BITS-1];
          if (phase == 2'h1) scl <= 1'b1;
          if (phase == 2'h3) begin
            scl <= 1'b0;
            tx <= {tx[FRAME_BITS-2:0], 1'b1};
            bit_idx <= bit_idx + 5'h01;
            if (bit_idx == ACK_B2 || nack) state <= H_STOP;
          end
        end
        H_STOP: begin
          if (phase == 2'h0) sda_oe <= 1'b1;
          if (phase == 2'h1) scl <= 1'b1;
          if (phase == 2'h2) sda_oe <= 1'b0;
          if (phase == 2'h3) state <= H_IDLE;
        end
        H_IDLE: begin
        end
      endcase
    end
  end

  assign LINK.scl = scl;
  assign LINK.rst_n = dev_rst_n;
  assign LINK.host_sda_oe = sda_oe;
  assign LINK.host_sda_o = 1'b0;

endmodule

/* verilog/cswd_pkg.sv */
// Purpose: Shared constants and types for the crosspoint write link
// Assumes: One controller and one switch array on the link
// Notes: Bit positions index the 24-bit command word
package cswd_pkg;
  localparam int CMD_BITS = 24;
  localparam int FRAME_BITS = 27;
  localparam logic [4:0] ACK_ADDR = 5'h08;
  localparam logic [4:0] NACK_STOP = 5'h09;
  localparam logic [4:0] ACK_B1 = 5'h11;
  localparam logic [4:0] ACK_B2 = 5'h1A;
  localparam logic [4:0] STOP_POS = 5'h1B;
  localparam logic [3:0] BUS_ADDR_HI = 4'hE;
  localparam logic RW_READ = 1'h1;
  localparam int DATA_POS = 15;
  localparam int X_MSB = 14;
  localparam int X_LSB = 11;
  localparam int Y_MSB = 10;
  localparam int Y_LSB = 8;
  localparam int LOAD_POS = 0;
  localparam int N_X = 12;
  localparam int N_Y = 8;
  localparam int N_SW = 96;
  localparam int X_LOW_LINES = 6;
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CFG_RST_POS = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int CLK_NS = 40;
  localparam int SCL_PERIOD_NS = 640;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BITS = 2'b10,
    H_STOP = 2'b11
  } cswd_hstate_e;
endpackage

/* verilog/cswd_link_if.sv */
// Purpose: Two-wire link between controller and switch array
// Assumes: Data line is open drain, pulled up when nobody drives
// Notes: Serial clock is push-pull from the controller only
`timescale 1ns/100ps
interface cswd_link_if;
  logic scl;
  logic rst_n;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Wired-AND of both drivers with a pull-up
  assign sda = !((host_sda_oe && !host_sda_o) ||
                 (dev_sda_oe && !dev_sda_o));
  modport host (
    output scl,
    output rst_n,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );
  modport device (
    input scl,
    input rst_n,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

/* verilog/cswd_sync.sv */
// Purpose: Two-flop synchroniser for levels from another domain
// Assumes: Each bit is an independent slow level
// Notes: No reset; output settles two edges after the clock runs
`timescale 1ns/100ps
module cswd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

/* verilog/cswd_device.sv */
// Purpose: Switch array end: decodes write frames into switch states
// Assumes: Clocked only by the serial clock; reset pin is async
// Notes: Switch states change only on serial clock rising edges or on device reset
`timescale 1ns/100ps
module cswd_device (
  cswd_link_if.device LINK,
  input wire logic ADDR_PIN_0,
  input wire logic ADDR_PIN_1,
  input wire logic ADDR_PIN_2,
  output logic [cswd_pkg::N_SW-1:0] SWITCH_ON,
  output logic [cswd_pkg::N_SW-1:0] LATCHED_ON
);
  import cswd_pkg::*;

  logic [2:0] pins;
  logic [CMD_BITS-1:0] switch_command_shift;
  logic [4:0] cnt;
  logic [4:0] eff_cnt;
  logic sda_hi;
  logic start_pend;
  logic start_now;
  logic addr_ok;
  logic addr_match;
  logic commit;
  logic [3:0] x_code;
  logic [2:0] y_line_select;
  logic [3:0] x_line;
  logic x_valid;
  logic [6:0] sw_idx;
  logic sw_state;
  logic load_switch_flag;
  logic [N_SW-1:0] next_latched;
  logic dev_oe;

  // Address straps come from pins outside the serial clock domain
  cswd_sync #(
    .W(3)
  ) u_pins (
    .clk(LINK.scl),
    .d({ADDR_PIN_2, ADDR_PIN_1, ADDR_PIN_0}),
    .q(pins)
  );

  // A start seen at the falling edge makes the next rise bit zero
  assign eff_cnt = start_pend ? 5'h00 : cnt;

  // Address byte sits in the low eight shift bits at the ack slot
  always_comb begin
    addr_match = 1'b0;
    if (switch_command_shift[7:4] == BUS_ADDR_HI &&
        switch_command_shift[3:1] == pins) begin
      addr_match = (switch_command_shift[0] != RW_READ);
    end
  end

  // Start: data high at the rise, low at the fall, clock high between
  assign start_now = sda_hi && !LINK.sda;

  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      sda_hi <= 1'b1;
    end else begin
      sda_hi <= LINK.sda;
    end
  end

  always_ff @(negedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= start_now;
    end
  end

  // Bit position within the frame, counted on rising edges
  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      cnt <= 5'h00;
    end else if (eff_cnt == STOP_POS) begin
      cnt <= 5'h00;
    end else if (eff_cnt == NACK_STOP && !addr_ok) begin
      // Controller stops after an unanswered address byte
      cnt <= 5'h00;
    end else begin
      cnt <= eff_cnt + 5'h01;
    end
  end

  // Data bits shift in; acknowledge slots and the stop rise do not
  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      switch_command_shift <= '0;
    end else if (eff_cnt != ACK_ADDR && eff_cnt != ACK_B1 &&
                 eff_cnt != ACK_B2 && eff_cnt != STOP_POS &&
                 !(eff_cnt == NACK_STOP && !addr_ok)) begin
      switch_command_shift <= {switch_command_shift[CMD_BITS-2:0],
                               LINK.sda};
    end
  end

  // Frame is ours once the address byte matched a write
  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      addr_ok <= 1'b0;
    end else if (eff_cnt == 5'h00) begin
      addr_ok <= 1'b0;
    end else if (eff_cnt == ACK_ADDR) begin
      addr_ok <= addr_match;
    end
  end

  // Acknowledge is driven from one falling edge to the next
  always_ff @(negedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      dev_oe <= 1'b0;
    end else if (start_now) begin
      dev_oe <= 1'b0;
    end else if (cnt == ACK_ADDR) begin
      dev_oe <= addr_match;
    end else if (cnt == ACK_B1 || cnt == ACK_B2) begin
      dev_oe <= addr_ok;
    end else begin
      dev_oe <= 1'b0;
    end
  end

  assign LINK.dev_sda_oe = dev_oe;
  assign LINK.dev_sda_o = 1'b0;

  // Command fields
  assign sw_state = switch_command_shift[DATA_POS];
  assign x_code = switch_command_shift[X_MSB:X_LSB];
  assign y_line_select = switch_command_shift[Y_MSB:Y_LSB];
  assign load_switch_flag = switch_command_shift[LOAD_POS];

  // X codes run 0..5 then 8..13; the two gaps select no line
  always_comb begin
    x_valid = (x_code[2:1] != 2'b11);
    if (x_code[3]) begin
      x_line = 4'(X_LOW_LINES) + {1'b0, x_code[2:0]};
    end else begin
      x_line = {1'b0, x_code[2:0]};
    end
  end

  // Every Y line pairs with every valid X line
  assign sw_idx = 7'({4'h0, y_line_select} * 7'(N_X)) +
                  {3'h0, x_line};

  // Commit at the rise of the last acknowledge, never earlier
  assign commit = (eff_cnt == ACK_B2) && addr_ok;

  always_comb begin
    next_latched = LATCHED_ON;
    if (commit && x_valid) begin
      next_latched[sw_idx] = sw_state;
    end
  end

  // Stored settings; reserved X codes change nothing
  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      LATCHED_ON <= '0;
    end else begin
      LATCHED_ON <= next_latched;
    end
  end

  // Load copies every stored setting to the switches at once
  always_ff @(posedge LINK.scl or negedge LINK.rst_n) begin
    if (!LINK.rst_n) begin
      SWITCH_ON <= '0;
    end else if (commit && load_switch_flag) begin
      SWITCH_ON <= next_latched;
    end
  end

endmodule

/* test/cswd_link_monitor.sv */
// Purpose: Watches the two-wire link for framing faults
// Assumes: Host built with QCYC of 2, so one bit is 8 CLK cycles
// Notes: Everything is sampled on CLK; the wire is slow beside it
`timescale 1ns/100ps
module cswd_link_monitor (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic scl,
  input wire logic rst_n,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Acknowledge holds one full scl period, fall to fall
  sequence ack_hold;
    dev_sda_oe[*8] ##1 !dev_sda_oe;
  endsequence
  sequence start_seen;
    $fell(sda) && scl;
  endsequence
  chk_idle_lines: assert property (disable iff (1'b0)
    SRST |=> scl && sda && !rst_n) else $error("link not idle in reset");
  chk_rst_release: assert property (
    $fell(SRST) |=> rst_n) else $error("device reset not released");
  chk_start_fall: assert property (
    start_seen |-> ##[1:8] !scl) else $error("no clock after start");
  chk_stop_idle: assert property (
    $rose(sda) && scl |-> scl[*4]) else $error("clock moved after stop");
  chk_scl_high: assert property (
    $rose(scl) |-> scl[*4]) else $error("short serial clock high");
  chk_ack_lowclk: assert property (
    $changed(dev_sda_oe) |-> !scl) else $error("ack moved with clock high");
  chk_ack_width: assert property (
    $rose(dev_sda_oe) |-> ack_hold) else $error("ack not one bit long");
  // Host may hold its last data bit one quarter past the fall
  chk_ack_release: assert property (
    dev_sda_oe && $past(dev_sda_oe, 2) |-> !host_sda_oe)
    else $error("host drives during ack");
  // A low clock means a frame is running
  chk_rst_steady: assert property (
    !scl |-> rst_n) else $error("device reset moved during a frame");
endmodule

/* test/crosspoint_switch_write_decoder_test.sv */
// Purpose: Drives commands over AXI and checks the switch array state
// Assumes: Host runs with QCYC of 2 to keep frames short
// Notes: Model tracks stored and live switch vectors per command
`timescale 1ns/100ps
module crosspoint_switch_write_decoder_test;
  import cswd_pkg::*;
  logic clk;
  logic srst;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] pins, tgt;
  logic [15:0] c;
  logic [95:0] sw_on, lat_on, exp_sw, exp_lat;
  int num_errors, check_count, i;
  integer seed;
  cswd_link_if cswd_link_if_inst();
  cswd_host #(.QCYC(2)) cswd_host_inst (.CLK(clk), .SRST(srst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .LINK(cswd_link_if_inst));
  cswd_device cswd_device_inst (.LINK(cswd_link_if_inst),
    .ADDR_PIN_0(pins[0]), .ADDR_PIN_1(pins[1]), .ADDR_PIN_2(pins[2]),
    .SWITCH_ON(sw_on), .LATCHED_ON(lat_on));
  cswd_link_monitor cswd_link_monitor_inst (.CLK(clk), .SRST(srst),
    .scl(cswd_link_if_inst.scl), .rst_n(cswd_link_if_inst.rst_n),
    .host_sda_oe(cswd_link_if_inst.host_sda_oe),
    .dev_sda_oe(cswd_link_if_inst.dev_sda_oe),
    .sda(cswd_link_if_inst.sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [95:0] g, input logic [95:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Launches one frame unless the X code is reserved, waits for idle, then compares with the model
  task automatic send(input logic [15:0] cmd);
    int x, xl, n;
    x = int'(cmd[X_MSB:X_LSB]);
    xl = x < X_LOW_LINES ? x : (x >= 8 && x < 14) ? x - 2 : -1;
    axi_wr(REG_CMD, {16'h0, cmd});
    check(96'(r), 96'(xl < 0 ? AXI_SLVERR : AXI_OKAY));
    n = 0;
    do begin
      axi_rd(REG_STATUS);
      n++;
    end while (d[STAT_BUSY] !== 1'b0 && n < 400);
    check(96'(d[STAT_BUSY]), 96'h0);
    if (tgt == pins && xl >= 0) begin
      exp_lat[int'(cmd[Y_MSB:Y_LSB]) * N_X + xl] = cmd[DATA_POS];
      if (cmd[LOAD_POS]) exp_sw = exp_lat;
    end
    check(sw_on, exp_sw);
    check(lat_on, exp_lat);
    check(96'(d[STAT_NACK]), 96'(tgt != pins));
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("ERROR at %0t: got %h exp %h", $time, 1'b0, 1'b1);
    give_verdict();
  end

  initial begin
    seed = 32'h61ce;
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pins = 3'($random(seed));
    tgt = pins;
    num_errors = 0;
    check_count = 0;
    exp_sw = 96'h0;
    exp_lat = 96'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(sw_on, 96'h0);
    check(lat_on, 96'h0);
    axi_rd(REG_CFG);
    check(96'(d), 96'(CFG_RESET));
    axi_rd(REG_CMD);
    check(96'(d), 96'(CMD_RESET));
    axi_rd(8'h0C);
    check(96'(r), 96'(AXI_SLVERR));
    axi_wr(REG_STATUS, 32'h3);
    check(96'(r), 96'(AXI_SLVERR));
    $display("test reset done");
    axi_wr(REG_CFG, {29'h0, tgt});
    check(96'(r), 96'(AXI_OKAY));
    // Every X code once and every Y code twice, random data, load and spare bits
    for (i = 0; i < 40; i++) begin
      c = 16'($random(seed));
      if (i < 16) c[X_MSB:Y_LSB] = {4'(i), 3'(i)};
      send(c);
    end
    $display("test decode done");
    tgt = pins ^ (3'($random(seed)) | 3'h1);
    axi_wr(REG_CFG, {29'h0, tgt});
    send(16'h8001);
    tgt = pins;
    axi_wr(REG_CFG, {29'h0, tgt});
    $display("test address done");
    // Reset asked for while a frame runs must wait for its stop
    axi_wr(REG_CMD, 32'h00008001);
    axi_wr(REG_CFG, {23'h0, 1'b1, 5'h0, tgt});
    do axi_rd(REG_STATUS); while (d[STAT_BUSY] !== 1'b0);
    check(96'(d[STAT_NACK]), 96'h0);
    repeat (2) @(posedge clk);
    exp_sw = 96'h0;
    exp_lat = 96'h0;
    check(sw_on, exp_sw);
    check(lat_on, exp_lat);
    axi_wr(REG_CFG, {29'h0, tgt});
    $display("test device reset done");
    send(16'h8000);
    send(16'h9100);
    send(16'h8A01);
    send(16'h0A00);
    send(16'h3001);
    $display("test latched done");
    give_verdict();
  end
endmodule
